// ---- design/rss_reset_sequencer.sv ----
// Reset source combiner, start-up sequencer and its register slave.
`timescale 1ns/1ps
module rss_reset_sequencer
  import rss_pkg::*;
#(
  parameter int POWERUP_TIMER_CNT = POWERUP_TIMER_CYCLES,
  parameter int REL_CNT = RELEASE_CYCLES
) (
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RESET,
  // Analog detectors and pin
  input wire logic I_POR_ACTIVE,
  input wire logic I_BOR_TRIP,
  input wire logic I_BOR_READY,
  input wire logic I_LOW_POWER_BROWNOUT_TRIP,
  input wire logic I_MASTER_CLEAR_PIN_PIN,
  // Core events
  input wire logic I_WDT_TIMEOUT,
  input wire logic I_WDT_CLEAR_INSTR,
  input wire logic I_RESET_INSTR,
  input wire logic I_STACK_OVF,
  input wire logic I_STACK_UNF,
  input wire logic I_PROG_EXIT,
  input wire logic I_SLEEP,
  // Core and analog controls
  output logic O_CPU_RESET,
  output logic O_WAKE_ALLOW,
  output logic O_BOR_ENABLE,
  output logic O_BANDGAP_FORCE,
  output logic O_LOW_POWER_BROWNOUT_ENABLE,
  output logic O_PULLUP_EN,
  output logic O_PIN_INPUT,
  // AXI4-Lite slave
  input wire logic [7:0] I_AXI_AWADDR,
  input wire logic I_AXI_AWVALID,
  output logic O_AXI_AWREADY,
  input wire logic [31:0] I_AXI_WDATA,
  input wire logic [3:0] I_AXI_WSTRB,
  input wire logic I_AXI_WVALID,
  output logic O_AXI_WREADY,
  output logic [1:0] O_AXI_BRESP,
  output logic O_AXI_BVALID,
  input wire logic I_AXI_BREADY,
  input wire logic [7:0] I_AXI_ARADDR,
  input wire logic I_AXI_ARVALID,
  output logic O_AXI_ARREADY,
  output logic [31:0] O_AXI_RDATA,
  output logic [1:0] O_AXI_RRESP,
  output logic O_AXI_RVALID,
  input wire logic I_AXI_RREADY
);

  if (POWERUP_TIMER_CNT < 1 || REL_CNT < 1) begin : g_bad
    $error("rss_reset_sequencer: counts must be at least one");
  end

  localparam int CW = $clog2(POWERUP_TIMER_CNT + REL_CNT + 1);

  // ----------------------------------------
  // Decoders
  // ----------------------------------------
  function automatic logic waits_ready(input rss_bor_mode_e m);
    return (m == BOR_ON) || (m == BOR_NOSLEEP);
  endfunction

  function automatic logic addr_known(input logic [7:0] a);
    return (a == ADDR_BOR_CTRL) || (a == ADDR_CAUSE) ||
           (a == ADDR_STATUS) || (a == ADDR_CONFIG);
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  rss_cond_if #(.W(SYN_W)) cond_if ();
  rss_state_e state_r;
  logic [CW-1:0] cnt_r;
  logic pin_seen_r;
  logic soft_en_r;
  logic fast_r;
  logic [7:0] cause_r;
  logic [7:0] cause_nxt;
  logic [1:0] status_r;
  logic [7:0] config_r;
  logic sleep_d_r;
  logic pin_input_r;
  logic aw_v_r;
  logic w_v_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic wr_go;
  logic wr_lane;
  rss_bor_mode_e mode;
  logic bor_en;
  logic bor_rst;
  logic low_power_brownout_rst;
  logic por_cond;
  logic ready_ok;
  logic pin_en;
  logic pin_hold;
  logic soft_rst;
  logic stk_rst;

  // ----------------------------------------
  // Input conditioning
  // ----------------------------------------
  assign cond_if.raw = {I_MASTER_CLEAR_PIN_PIN, I_LOW_POWER_BROWNOUT_TRIP, I_BOR_READY, I_BOR_TRIP, I_POR_ACTIVE};

  rss_input_cond #(
    .W(SYN_W),
    .PIN_IDX(SYN_MASTER_CLEAR_PIN),
    .FILTER(MASTER_CLEAR_PIN_FILTER_CYCLES)
  ) u_cond (
    .i_clk(I_MCLK),
    .i_rst(I_RESET),
    .c(cond_if.cond)
  );

  // ----------------------------------------
  // Source combination
  // ----------------------------------------
  assign mode = rss_bor_mode_e'(config_r[CF_MODE +: 2]);

  // The software enable bit is consulted in software mode only.
  always_comb begin
    case (mode)
      BOR_ON: bor_en = 1'b1;
      BOR_NOSLEEP: bor_en = !I_SLEEP;
      BOR_SOFT: bor_en = soft_en_r;
      default: bor_en = 1'b0;
    endcase
  end

  // Protection only acts once the circuit reports ready.
  assign bor_rst = bor_en && cond_if.stable[SYN_RDY] && cond_if.stable[SYN_TRIP];
  assign low_power_brownout_rst = !config_r[CF_LOW_POWER_BROWNOUT_N] && cond_if.stable[SYN_LOW_POWER_BROWNOUT];
  assign por_cond = cond_if.stable[SYN_POR] || bor_rst || low_power_brownout_rst || I_PROG_EXIT;
  assign ready_ok = !waits_ready(mode) ||
                    (cond_if.stable[SYN_RDY] && !cond_if.stable[SYN_TRIP]);
  assign pin_en = config_r[CF_MASTER_CLEAR_ENABLE_CFG] || config_r[CF_LVP];
  assign pin_hold = pin_en && cond_if.pin_low;
  assign stk_rst = config_r[CF_STACK_RESET_ENABLE_CFG] && (I_STACK_OVF || I_STACK_UNF);
  assign soft_rst = I_WDT_TIMEOUT || I_RESET_INSTR || stk_rst;

  // ----------------------------------------
  // Start-up sequencer
  // ----------------------------------------
  // A pin that is still low after the timer adds the release delay.
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      state_r <= SQ_HOLD;
      cnt_r <= '0;
      pin_seen_r <= 1'b0;
    end else begin
      case (state_r)
        SQ_HOLD: begin
          cnt_r <= '0;
          pin_seen_r <= 1'b0;
          if (!por_cond && ready_ok) begin
            if (!config_r[CF_POWERUP_TIMER_ENABLE_N_N]) begin
              state_r <= SQ_POWERUP_TIMER;
            end else begin
              state_r <= SQ_PIN;
            end
          end
        end
        SQ_POWERUP_TIMER: begin
          if (por_cond) begin
            state_r <= SQ_HOLD;
          end else if (cnt_r == CW'(POWERUP_TIMER_CNT - 1)) begin
            cnt_r <= '0;
            state_r <= SQ_PIN;
          end else begin
            cnt_r <= cnt_r + CW'(1);
          end
        end
        SQ_PIN: begin
          cnt_r <= '0;
          if (por_cond) begin
            state_r <= SQ_HOLD;
          end else if (pin_hold) begin
            pin_seen_r <= 1'b1;
          end else if (pin_seen_r) begin
            state_r <= SQ_RELEASE;
          end else begin
            state_r <= SQ_RUN;
          end
        end
        SQ_RELEASE: begin
          pin_seen_r <= 1'b0;
          if (por_cond) begin
            state_r <= SQ_HOLD;
          end else if (pin_hold) begin
            cnt_r <= '0;
            state_r <= SQ_PIN;
          end else if (cnt_r == CW'(REL_CNT - 1)) begin
            cnt_r <= '0;
            state_r <= SQ_RUN;
          end else begin
            cnt_r <= cnt_r + CW'(1);
          end
        end
        SQ_RUN: begin
          cnt_r <= '0;
          if (por_cond) begin
            state_r <= SQ_HOLD;
          end else if (pin_hold) begin
            state_r <= SQ_PIN;
          end else if (soft_rst) begin
            state_r <= SQ_RELEASE;
          end
        end
        default: state_r <= SQ_HOLD;
      endcase
    end
  end

  assign O_CPU_RESET = (state_r != SQ_RUN);
  assign O_WAKE_ALLOW = (mode != BOR_NOSLEEP) || cond_if.stable[SYN_RDY];
  assign O_BOR_ENABLE = bor_en;
  assign O_BANDGAP_FORCE = (mode == BOR_NOSLEEP || mode == BOR_SOFT) && fast_r;
  assign O_LOW_POWER_BROWNOUT_ENABLE = !config_r[CF_LOW_POWER_BROWNOUT_N];
  assign O_PULLUP_EN = pin_en || config_r[CF_PULLUP];
  assign O_PIN_INPUT = pin_input_r;

  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      pin_input_r <= 1'b0;
    end else begin
      pin_input_r <= !pin_en && cond_if.stable[SYN_MASTER_CLEAR_PIN];
    end
  end

  // ----------------------------------------
  // Reset cause flags
  // ----------------------------------------
  // Hardware events win over a software write in the same cycle.
  always_comb begin
    cause_nxt = cause_r;
    if (wr_go && wr_lane && awaddr_r == ADDR_CAUSE) begin
      cause_nxt = wdata_r[7:0] & CAUSE_MASK;
    end
    if (I_STACK_OVF) begin
      cause_nxt[CS_STACK_OVERFLOW_FLAG] = 1'b1;
    end
    if (I_STACK_UNF) begin
      cause_nxt[CS_STACK_UNDERFLOW_FLAG] = 1'b1;
    end
    if (I_WDT_TIMEOUT) begin
      cause_nxt[CS_RWDT] = 1'b0;
    end
    if (pin_hold) begin
      cause_nxt[CS_RMCLR] = 1'b0;
    end
    if (I_RESET_INSTR) begin
      cause_nxt[CS_RI] = 1'b0;
    end
    if (bor_rst || low_power_brownout_rst) begin
      cause_nxt[CS_BOR] = 1'b0;
      cause_nxt[CS_RWDT] = 1'b1;
      cause_nxt[CS_RMCLR] = 1'b1;
      cause_nxt[CS_RI] = 1'b1;
    end
    if (cond_if.stable[SYN_POR] || I_PROG_EXIT) begin
      cause_nxt = CAUSE_RST;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      cause_r <= CAUSE_RST;
    end else begin
      cause_r <= cause_nxt;
    end
  end

  // ----------------------------------------
  // Timeout and power-down flags
  // ----------------------------------------
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      status_r <= STATUS_RST;
      sleep_d_r <= 1'b0;
    end else begin
      sleep_d_r <= I_SLEEP;
      if (por_cond || I_WDT_CLEAR_INSTR) begin
        status_r <= STATUS_RST;
      end else if (I_WDT_TIMEOUT) begin
        status_r[ST_TO] <= 1'b0;
        if (I_SLEEP) begin
          status_r[ST_PD] <= 1'b0;
        end
      end else if (I_SLEEP && !sleep_d_r) begin
        status_r[ST_TO] <= 1'b1;
        status_r[ST_PD] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  assign wr_go = aw_v_r && w_v_r && !bvalid_r;
  assign wr_lane = wstrb_r[0];

  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      soft_en_r <= BC_SOFT_EN_RST;
      fast_r <= BC_FAST_RST;
    end else if (wr_go && wr_lane && awaddr_r == ADDR_BOR_CTRL) begin
      soft_en_r <= wdata_r[BC_SOFT_EN];
      fast_r <= wdata_r[BC_FAST];
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      config_r <= CONFIG_RST;
    end else if (wr_go && wr_lane && awaddr_r == ADDR_CONFIG) begin
      config_r <= wdata_r[7:0];
    end
  end

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  assign O_AXI_AWREADY = !aw_v_r && !bvalid_r;
  assign O_AXI_WREADY = !w_v_r && !bvalid_r;
  assign O_AXI_BVALID = bvalid_r;
  assign O_AXI_BRESP = bresp_r;

  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      aw_v_r <= 1'b0;
      w_v_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (I_AXI_AWVALID && O_AXI_AWREADY) begin
        aw_v_r <= 1'b1;
        awaddr_r <= I_AXI_AWADDR;
      end
      if (I_AXI_WVALID && O_AXI_WREADY) begin
        w_v_r <= 1'b1;
        wdata_r <= I_AXI_WDATA;
        wstrb_r <= I_AXI_WSTRB;
      end
      if (wr_go) begin
        aw_v_r <= 1'b0;
        w_v_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= addr_known(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && I_AXI_BREADY) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  assign O_AXI_ARREADY = !rvalid_r;
  assign O_AXI_RVALID = rvalid_r;
  assign O_AXI_RDATA = rdata_r;
  assign O_AXI_RRESP = rresp_r;

  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (I_AXI_ARVALID && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rresp_r <= addr_known(I_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
      rdata_r <= 32'h0000_0000;
      case (I_AXI_ARADDR)
        ADDR_BOR_CTRL: begin
          rdata_r[BC_SOFT_EN] <= soft_en_r;
          rdata_r[BC_FAST] <= fast_r;
          rdata_r[BC_READY] <= cond_if.stable[SYN_RDY];
        end
        ADDR_CAUSE: rdata_r[7:0] <= cause_r;
        ADDR_STATUS: rdata_r[1:0] <= status_r;
        ADDR_CONFIG: rdata_r[7:0] <= config_r;
        default: rdata_r <= 32'h0000_0000;
      endcase
    end else if (rvalid_r && I_AXI_RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule // rss_reset_sequencer

// ---- shared/rss_pkg.sv ----
// Constants and types of the reset source sequencer.
package rss_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int POWERUP_TIMER_TIME_MS = 64;
  localparam int POWERUP_TIMER_CYCLES = POWERUP_TIMER_TIME_MS * (CLK_HZ / 1000);
  localparam int RELEASE_CYCLES = 10;
  localparam int MASTER_CLEAR_PIN_FILTER_NS = 200;
  localparam int MASTER_CLEAR_PIN_FILTER_CYCLES = MASTER_CLEAR_PIN_FILTER_NS * (CLK_HZ / 1_000_000) / 1000;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_BOR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CAUSE = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CONFIG = 8'h0C;

  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int BC_SOFT_EN = 7;
  localparam int BC_FAST = 6;
  localparam int BC_READY = 0;
  localparam logic BC_SOFT_EN_RST = 1'b1;
  localparam logic BC_FAST_RST = 1'b0;
  localparam int CS_STACK_OVERFLOW_FLAG = 7;
  localparam int CS_STACK_UNDERFLOW_FLAG = 6;
  localparam int CS_RWDT = 4;
  localparam int CS_RMCLR = 3;
  localparam int CS_RI = 2;
  localparam int CS_POR = 1;
  localparam int CS_BOR = 0;
  localparam logic [7:0] CAUSE_MASK = 8'hDF;
  localparam logic [7:0] CAUSE_RST = 8'h1C;
  localparam int ST_TO = 1;
  localparam int ST_PD = 0;
  localparam logic [1:0] STATUS_RST = 2'h3;
  localparam int CF_MODE = 0;
  localparam int CF_POWERUP_TIMER_ENABLE_N_N = 2;
  localparam int CF_MASTER_CLEAR_ENABLE_CFG = 3;
  localparam int CF_LVP = 4;
  localparam int CF_LOW_POWER_BROWNOUT_N = 5;
  localparam int CF_STACK_RESET_ENABLE_CFG = 6;
  localparam int CF_PULLUP = 7;
  localparam logic [7:0] CONFIG_RST = 8'hFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // Synchronised analog inputs and pin
  // ----------------------------------------
  localparam int SYN_POR = 0;
  localparam int SYN_TRIP = 1;
  localparam int SYN_RDY = 2;
  localparam int SYN_LOW_POWER_BROWNOUT = 3;
  localparam int SYN_MASTER_CLEAR_PIN = 4;
  localparam int SYN_W = 5;

  typedef enum logic [1:0] {
    BOR_OFF = 2'h0,
    BOR_SOFT = 2'h1,
    BOR_NOSLEEP = 2'h2,
    BOR_ON = 2'h3
  } rss_bor_mode_e;

  typedef enum logic [2:0] {
    SQ_HOLD = 3'h0,
    SQ_POWERUP_TIMER = 3'h1,
    SQ_PIN = 3'h3,
    SQ_RELEASE = 3'h2,
    SQ_RUN = 3'h6
  } rss_state_e;

endpackage

// ---- shared/rss_cond_if.sv ----
// Interface between the sequencer and its input conditioner.
`timescale 1ns/1ps
interface rss_cond_if #(parameter int W = 5);
  logic [W-1:0] raw;
  logic [W-1:0] stable;
  logic pin_low;
  modport cond (input raw, output stable, output pin_low);
  modport core (output raw, input stable, input pin_low);
endinterface

// ---- design/rss_input_cond.sv ----
// Three-stage synchronisers and the master-clear pin filter.
`timescale 1ns/1ps
module rss_input_cond
  import rss_pkg::*;
#(
  parameter int W = SYN_W,
  parameter int PIN_IDX = SYN_MASTER_CLEAR_PIN,
  parameter int FILTER = MASTER_CLEAR_PIN_FILTER_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Conditioned signals
  rss_cond_if.cond c
);

  if (FILTER < 1 || PIN_IDX >= W) begin : g_bad
    $error("rss_input_cond: bad parameters");
  end

  localparam int FW = $clog2(FILTER + 1);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] stable_r;
  logic [FW-1:0] low_cnt_r;
  logic pin_low_r;

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  // A level only counts once two late stages agree.
  for (genvar g = 0; g < W; g++) begin : g_sync
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        s1_r[g] <= 1'b0;
        s2_r[g] <= 1'b0;
        s3_r[g] <= 1'b0;
        stable_r[g] <= 1'b0;
      end else begin
        s1_r[g] <= c.raw[g];
        s2_r[g] <= s1_r[g];
        s3_r[g] <= s2_r[g];
        if (s2_r[g] == s3_r[g]) begin
          stable_r[g] <= s3_r[g];
        end
      end
    end
  end

  // ----------------------------------------
  // Pin filter
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      low_cnt_r <= '0;
      pin_low_r <= 1'b0;
    end else if (stable_r[PIN_IDX]) begin
      low_cnt_r <= '0;
      pin_low_r <= 1'b0;
    end else if (low_cnt_r != FW'(FILTER)) begin
      low_cnt_r <= low_cnt_r + FW'(1);
    end else begin
      pin_low_r <= 1'b1;
    end
  end

  assign c.stable = stable_r;
  assign c.pin_low = pin_low_r;

endmodule // rss_input_cond

// ---- tb/rss_core_model.sv ----
// Behavioural model of the core event source and the reset pin driver.
`timescale 1ns/1ps
module rss_core_model (
  // Clock
  input wire logic clk,
  // Pin and core signals
  output logic pin,
  output logic sleep,
  output logic [5:0] ev
);
  logic pull_low = 1'b0;
  initial begin
    sleep = 1'b0;
    ev = 6'h00;
  end
  // A released pin reads high through the weak pull-up, never a held value.
  assign pin = pull_low ? 1'b0 : 1'b1;
  task automatic drive(input logic p, input logic s);
    @(posedge clk);
    pull_low <= !p;
    sleep <= s;
  endtask
  // Events are one-cycle pulses: 0 timeout, 1 clear, 2 reset, 3 ovf, 4 unf, 5 exit.
  task automatic pulse(input int b);
    @(posedge clk);
    ev <= 6'h01 << b;
    @(posedge clk);
    ev <= 6'h00;
  endtask
endmodule // rss_core_model

// ---- tb/rss_reset_sequencer_asserts.sv ----
// Port-level checks of the reset sequencer.
`timescale 1ns/1ps
module rss_reset_sequencer_asserts (
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RESET,
  // Sources
  input wire logic I_POR_ACTIVE,
  input wire logic I_MASTER_CLEAR_PIN_PIN,
  input wire logic I_WDT_TIMEOUT,
  input wire logic I_WDT_CLEAR_INSTR,
  input wire logic I_RESET_INSTR,
  input wire logic O_CPU_RESET,
  // Register bus
  input wire logic I_AXI_AWVALID,
  input wire logic O_AXI_AWREADY,
  input wire logic I_AXI_WVALID,
  input wire logic O_AXI_WREADY,
  input wire logic [1:0] O_AXI_BRESP,
  input wire logic O_AXI_BVALID,
  input wire logic I_AXI_BREADY,
  input wire logic I_AXI_ARVALID,
  input wire logic O_AXI_ARREADY,
  input wire logic [31:0] O_AXI_RDATA,
  input wire logic [1:0] O_AXI_RRESP,
  input wire logic O_AXI_RVALID,
  input wire logic I_AXI_RREADY
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_RESET);
  // A synchronous release stage holds the core at least this long.
  sequence s_held;
    O_CPU_RESET [*8];
  endsequence
  AST_RST_HOLD: assert property (disable iff (1'b0) I_RESET |=> O_CPU_RESET)
    else $error("reset input did not hold core");
  AST_POR_HOLD: assert property (I_POR_ACTIVE [*6] |-> O_CPU_RESET)
    else $error("power-on did not hold core");
  AST_WDT_RESET: assert property (I_WDT_TIMEOUT && !I_WDT_CLEAR_INSTR && !O_CPU_RESET |=> s_held)
    else $error("watchdog reset too short");
  AST_RI_RESET: assert property (I_RESET_INSTR && !O_CPU_RESET |=> s_held)
    else $error("reset instruction hold too short");
  AST_PIN_RELEASE: assert property ($rose(I_MASTER_CLEAR_PIN_PIN) && O_CPU_RESET |=> s_held)
    else $error("pin release came too soon");
  AST_B_STANDS: assert property (O_AXI_BVALID && !I_AXI_BREADY |=> O_AXI_BVALID && $stable(O_AXI_BRESP))
    else $error("write response dropped");
  AST_R_STANDS: assert property (O_AXI_RVALID && !I_AXI_RREADY |=>
    O_AXI_RVALID && $stable(O_AXI_RDATA) && $stable(O_AXI_RRESP))
    else $error("read response dropped");
  AST_AR_REFUSE: assert property (O_AXI_RVALID |-> !O_AXI_ARREADY)
    else $error("read address taken while busy");
  AST_R_ANSWER: assert property (I_AXI_ARVALID && O_AXI_ARREADY |=> O_AXI_RVALID)
    else $error("read answer late");
  AST_B_ANSWER: assert property (I_AXI_AWVALID && O_AXI_AWREADY && I_AXI_WVALID && O_AXI_WREADY
    |=> ##1 O_AXI_BVALID)
    else $error("write answer late");
  AST_RDATA_PAD: assert property (O_AXI_RVALID |-> O_AXI_RDATA[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
endmodule // rss_reset_sequencer_asserts
bind rss_reset_sequencer rss_reset_sequencer_asserts chk_u (.I_MCLK(I_MCLK), .I_RESET(I_RESET),
  .I_POR_ACTIVE(I_POR_ACTIVE), .I_MASTER_CLEAR_PIN_PIN(I_MASTER_CLEAR_PIN_PIN), .I_WDT_TIMEOUT(I_WDT_TIMEOUT),
  .I_WDT_CLEAR_INSTR(I_WDT_CLEAR_INSTR), .I_RESET_INSTR(I_RESET_INSTR),
  .O_CPU_RESET(O_CPU_RESET), .I_AXI_AWVALID(I_AXI_AWVALID), .O_AXI_AWREADY(O_AXI_AWREADY),
  .I_AXI_WVALID(I_AXI_WVALID), .O_AXI_WREADY(O_AXI_WREADY), .O_AXI_BRESP(O_AXI_BRESP),
  .O_AXI_BVALID(O_AXI_BVALID), .I_AXI_BREADY(I_AXI_BREADY), .I_AXI_ARVALID(I_AXI_ARVALID),
  .O_AXI_ARREADY(O_AXI_ARREADY), .O_AXI_RDATA(O_AXI_RDATA), .O_AXI_RRESP(O_AXI_RRESP),
  .O_AXI_RVALID(O_AXI_RVALID), .I_AXI_RREADY(I_AXI_RREADY));

// ---- tb/testbench.sv ----
// Self-checking bench for the reset source sequencer.
`timescale 1ns/1ps
module testbench;
  import rss_pkg::*;
  localparam int POWERUP_TIMER_SIM = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic por = 1'b0, bor_trip = 1'b0, bor_rdy = 1'b1, lp_trip = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire logic awready, wready, bvalid, arready, rvalid, pin, sleep;
  wire logic cpu_rst, wake, bor_en, bg_force, lp_en, pull_en, pin_in;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [5:0] ev;
  wire logic ev_wdt = ev[0], ev_clr = ev[1], ev_ri = ev[2];
  wire logic ev_ovf = ev[3], ev_unf = ev[4], ev_exit = ev[5];
  logic [3:0] wstrb = 4'hF;
  logic [7:0] cfg [3] = '{8'hE7, 8'hEF, 8'hF7};
  int fails = 0;
  int n_tests = 0;
  always #25 clk = ~clk;
  rss_core_model core_u (.clk(clk), .pin(pin), .sleep(sleep), .ev(ev));
  rss_reset_sequencer #(.POWERUP_TIMER_CNT(POWERUP_TIMER_SIM)) dut_u (.I_MCLK(clk), .I_RESET(rst),
    .I_POR_ACTIVE(por), .I_BOR_TRIP(bor_trip), .I_BOR_READY(bor_rdy), .I_LOW_POWER_BROWNOUT_TRIP(lp_trip),
    .I_MASTER_CLEAR_PIN_PIN(pin), .I_WDT_TIMEOUT(ev_wdt), .I_WDT_CLEAR_INSTR(ev_clr), .I_RESET_INSTR(ev_ri),
    .I_STACK_OVF(ev_ovf), .I_STACK_UNF(ev_unf), .I_PROG_EXIT(ev_exit), .I_SLEEP(sleep),
    .O_CPU_RESET(cpu_rst), .O_WAKE_ALLOW(wake), .O_BOR_ENABLE(bor_en),
    .O_BANDGAP_FORCE(bg_force), .O_LOW_POWER_BROWNOUT_ENABLE(lp_en), .O_PULLUP_EN(pull_en),
    .O_PIN_INPUT(pin_in), .I_AXI_AWADDR(awaddr), .I_AXI_AWVALID(awvalid),
    .O_AXI_AWREADY(awready), .I_AXI_WDATA(wdata), .I_AXI_WSTRB(wstrb), .I_AXI_WVALID(wvalid),
    .O_AXI_WREADY(wready), .O_AXI_BRESP(bresp), .O_AXI_BVALID(bvalid), .I_AXI_BREADY(bready),
    .I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arvalid), .O_AXI_ARREADY(arready),
    .O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp), .O_AXI_RVALID(rvalid), .I_AXI_RREADY(rready));
  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    n_tests++;
    if (act !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, act, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Offsets above the last register answer with an error.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      aw_ok = aw_ok || awready;
      w_ok = w_ok || wready;
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
    chk(32'(bresp), 32'(a > ADDR_CONFIG ? RESP_SLVERR : RESP_OKAY));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
    chk(rdata, ed);
    chk(32'(rresp), 32'(a > ADDR_CONFIG ? RESP_SLVERR : RESP_OKAY));
  endtask
  // Counts the cycles the core stays held; the bound keeps a stuck reset from hanging.
  task automatic held(output logic [31:0] n);
    n = 0;
    @(posedge clk);
    while (cpu_rst && n < 32'd3000) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #(50 * 20000);
    fails++;
    complete_run;
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    logic [31:0] n;
    cyc(10);
    rst <= 1'b0;
    held(n);
    chk(32'(lp_en), 0);
    rd(ADDR_BOR_CTRL, 32'h0000_0081);
    rd(ADDR_CAUSE, 32'h0000_001C);
    rd(ADDR_STATUS, 32'h0000_0003);
    rd(ADDR_CONFIG, 32'h0000_00FF);
    rd(8'h10, 32'h0000_0000);
    wr(8'h10, 32'h0000_0000);
    wr(ADDR_BOR_CTRL, 32'h0000_00FF);
    rd(ADDR_BOR_CTRL, 32'h0000_00C1);
    // Without the low byte lane a write must leave the register alone.
    wstrb <= 4'hE;
    wr(ADDR_BOR_CTRL, 32'h0000_0000);
    wstrb <= 4'hF;
    rd(ADDR_BOR_CTRL, 32'h0000_00C1);
    core_u.pulse(0);
    held(n);
    rd(ADDR_CAUSE, 32'h0000_000C);
    rd(ADDR_STATUS, 32'h0000_0001);
    core_u.pulse(1);
    rd(ADDR_STATUS, 32'h0000_0003);
    core_u.pulse(2);
    held(n);
    chk(32'(n inside {[9:13]}), 1);
    rd(ADDR_CAUSE, 32'h0000_0008);
    core_u.drive(0, 0);
    cyc(1);
    core_u.drive(1, 0);
    cyc(12);
    chk(32'(cpu_rst), 0);
    core_u.drive(0, 0);
    cyc(30);
    chk(32'(cpu_rst), 1);
    core_u.drive(1, 0);
    held(n);
    chk(32'(n inside {[10:18]}), 1);
    rd(ADDR_CAUSE, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CONFIG, 32'(cfg[i]));
      cyc(6);
      chk(32'(pin_in), 32'(i == 0));
    end
    wr(ADDR_CONFIG, 32'h0000_00E7);
    core_u.drive(0, 0);
    cyc(30);
    chk(32'(cpu_rst), 0);
    chk(32'(pin_in), 0);
    core_u.drive(1, 0);
    chk(32'(pull_en), 1);
    wr(ADDR_CONFIG, 32'h0000_0067);
    chk(32'(pull_en), 0);
    wr(ADDR_CONFIG, 32'h0000_00BF);
    core_u.pulse(4);
    cyc(4);
    chk(32'(cpu_rst), 0);
    wr(ADDR_CONFIG, 32'h0000_00FF);
    wr(ADDR_CAUSE, 32'h0000_001F);
    core_u.pulse(3);
    held(n);
    rd(ADDR_CAUSE, 32'h0000_009F);
    wr(ADDR_CAUSE, 32'h0000_001F);
    rd(ADDR_CAUSE, 32'h0000_001F);
    wr(ADDR_BOR_CTRL, 32'h0000_00C0);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CONFIG, 32'(8'hFC | i));
      chk(32'(bg_force), 32'(i == 1 || i == 2));
      chk(32'(bor_en), 32'(i != 0));
    end
    wr(ADDR_CONFIG, 32'h0000_00FD);
    wr(ADDR_BOR_CTRL, 32'h0000_0040);
    chk(32'(bor_en), 0);
    wr(ADDR_CONFIG, 32'h0000_00FE);
    core_u.drive(1, 1);
    cyc(2);
    chk(32'(bor_en), 0);
    bor_rdy <= 1'b0;
    cyc(6);
    chk(32'(wake), 0);
    wr(ADDR_CONFIG, 32'h0000_00FF);
    chk(32'(bor_en), 1);
    chk(32'(wake), 1);
    rd(ADDR_BOR_CTRL, 32'h0000_0040);
    bor_rdy <= 1'b1;
    core_u.drive(1, 0);
    wr(ADDR_CONFIG, 32'h0000_00DF);
    chk(32'(lp_en), 1);
    wr(ADDR_CONFIG, 32'h0000_00FB);
    por <= 1'b1;
    cyc(8);
    por <= 1'b0;
    held(n);
    chk(32'(n inside {[POWERUP_TIMER_SIM:POWERUP_TIMER_SIM + 10]}), 1);
    rd(ADDR_CAUSE, 32'h0000_001C);
    wr(ADDR_CAUSE, 32'h0000_001F);
    core_u.pulse(5);
    held(n);
    chk(32'(n inside {[POWERUP_TIMER_SIM:POWERUP_TIMER_SIM + 10]}), 1);
    rd(ADDR_CAUSE, 32'h0000_001C);
    core_u.drive(0, 0);
    por <= 1'b1;
    cyc(8);
    por <= 1'b0;
    cyc(60);
    chk(32'(cpu_rst), 1);
    core_u.drive(1, 0);
    held(n);
    chk(32'(n inside {[10:18]}), 1);
    wr(ADDR_CONFIG, 32'h0000_00DF);
    por <= 1'b1;
    cyc(8);
    por <= 1'b0;
    held(n);
    chk(32'(n < POWERUP_TIMER_SIM), 1);
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_CAUSE, 32'h0000_001F);
      if (i == 0) lp_trip <= 1'b1;
      else bor_trip <= 1'b1;
      cyc(8);
      lp_trip <= 1'b0;
      bor_trip <= 1'b0;
      held(n);
      rd(ADDR_CAUSE, 32'h0000_001E);
    end
    complete_run;
  end
endmodule // testbench
